// ==== hw/rx_overhead_regs.vh ====
// Constants for the receive overhead serial output port
`ifndef RX_OVERHEAD_REGS_VH
`define RX_OVERHEAD_REGS_VH

// Frame layout
`define E3_FRAME_BITS      1536
`define OH_BITS_PER_FRAME  12
`define OH_CNT_W           4
`define OH_LAST_INDEX      4'hB

// Overhead clock timing: half period of the overhead clock
`define MCLK_PERIOD_NS     10
`define OH_HALF_PERIOD_NS  40
`define OH_HALF_CYCLES     (`OH_HALF_PERIOD_NS / `MCLK_PERIOD_NS)

// Reset values
`define OH_CLK_RESET       1'h0
`define OH_DATA_RESET      1'h0
`define OH_FRAME_RESET     1'h0
`define OH_OVERRUN_RESET   1'h0
`define OH_PEND_RESET      1'h0

`endif

// ==== hw/rx_overhead_serial_port.v ====
// Receive overhead serial output port with free running overhead clock
// Operation
// - Overhead bits leave serially; data changes on the overhead clock falling edge.
// - Frame start high exactly one overhead clock period with first overhead bit.
// - Overhead data output always enabled; no disable input or bit exists.
// - Overhead clock runs continuously, never stopped or gated.
// - Count 11 is alignment bit 9, 10..2 bits 8..0, 1 A, 0 N.
// - An E3 frame is 1536 bits, twelve of them overhead bits.
`timescale 1ns/1ps
`default_nettype none
`include "rx_overhead_regs.vh"

module rx_overhead_serial_port #(
   parameter HALF_CYCLES = `OH_HALF_CYCLES,
   parameter DIV_W       = 8
) (
   // Clock and reset
   input  wire                          mclk,
   input  wire                          reset,
   // Overhead word from the receive framer, one per E3 frame
   input  wire                          ovh_load,
   input  wire [`OH_BITS_PER_FRAME-1:0] ovh_word,
   // Overhead serial link to terminal equipment
   output reg                           rx_overhead_serial_out,
   output reg                           rx_overhead_bit_clock,
   output reg                           rx_overhead_frame_start,
   // Status
   output reg                           ovh_overrun
);

   ////////////////////////////////////////////////////////////////////////////
   // Local constants

   localparam integer                  DIV_LAST_I = HALF_CYCLES - 1;
   localparam [DIV_W-1:0]              DIV_LAST   = DIV_LAST_I[DIV_W-1:0];
   localparam [DIV_W-1:0]              DIV_ZERO   = {DIV_W{1'h0}};
   localparam [DIV_W-1:0]              DIV_ONE    = {{(DIV_W-1){1'h0}}, 1'h1};
   localparam [`OH_CNT_W-1:0]          CNT_ZERO   = {`OH_CNT_W{1'h0}};
   localparam [`OH_CNT_W-1:0]          CNT_ONE    = {{(`OH_CNT_W-1){1'h0}}, 1'h1};
   localparam [`OH_CNT_W-1:0]          CNT_LAST   = `OH_LAST_INDEX;
   localparam [`OH_BITS_PER_FRAME-1:0] WORD_ZERO  = {`OH_BITS_PER_FRAME{1'h0}};
   localparam integer                  MSB        = `OH_BITS_PER_FRAME - 1;

   // Serialiser states, one-hot
   localparam [1:0]                    ST_IDLE    = 2'h1;
   localparam [1:0]                    ST_SHIFT   = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // State and next-state signals

   reg  [DIV_W-1:0]              div_q;
   reg  [DIV_W-1:0]              div_d;
   reg                           clk_d;
   reg  [1:0]                    state_q;
   reg  [1:0]                    state_d;
   reg  [`OH_CNT_W-1:0]          cnt_q;
   reg  [`OH_CNT_W-1:0]          cnt_d;
   reg  [`OH_BITS_PER_FRAME-1:0] sh_q;
   wire [`OH_BITS_PER_FRAME-1:0] sh_d;
   reg  [`OH_BITS_PER_FRAME-1:0] pend_word_q;
   reg  [`OH_BITS_PER_FRAME-1:0] pend_word_d;
   reg                           pend_q;
   reg                           pend_d;
   reg                           overrun_d;
   reg                           data_d;
   reg                           frame_d;
   reg                           take_word;
   reg                           shift_word;
   wire                          half_done;
   wire                          falling;
   wire                          word_done;

   genvar                        g;

   assign half_done = (div_q == DIV_LAST);
   assign falling   = half_done & rx_overhead_bit_clock;
   assign word_done = (cnt_q == CNT_ZERO);

   ////////////////////////////////////////////////////////////////////////////
   // Overhead clock divider; free running from reset on, with no gate or enable

   always @* begin
      div_d = div_q + DIV_ONE;
      clk_d = rx_overhead_bit_clock;
      if (half_done) begin
         div_d = DIV_ZERO;
         clk_d = ~rx_overhead_bit_clock;
      end
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         div_q                 <= DIV_ZERO;
         rx_overhead_bit_clock <= `OH_CLK_RESET;
      end else begin
         div_q                 <= div_d;
         rx_overhead_bit_clock <= clk_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serialiser control
   // Data and frame start move only on the edge where the bit clock falls, so the
   // far end gets half a bit period of settling before its rising edge

   always @* begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      data_d     = rx_overhead_serial_out;
      frame_d    = rx_overhead_frame_start;
      take_word  = 1'h0;
      shift_word = 1'h0;
      case (state_q)
         ST_IDLE: begin
            if (falling) begin
               if (pend_q) begin
                  take_word = 1'h1;
                  state_d   = ST_SHIFT;
                  cnt_d     = CNT_LAST;
                  data_d    = pend_word_q[MSB];
                  frame_d   = 1'h1;
               end else begin
                  data_d    = 1'h0;
                  frame_d   = 1'h0;
               end
            end
         end
         ST_SHIFT: begin
            if (falling) begin
               if (!word_done) begin
                  shift_word = 1'h1;
                  cnt_d      = cnt_q - CNT_ONE;
                  data_d     = sh_q[MSB];
                  frame_d    = 1'h0;
               end else if (pend_q) begin
                  // Back to back words: the next one starts right after the N bit
                  take_word  = 1'h1;
                  cnt_d      = CNT_LAST;
                  data_d     = pend_word_q[MSB];
                  frame_d    = 1'h1;
               end else begin
                  // Idle between frames drives zero; the far end ignores these bits
                  state_d    = ST_IDLE;
                  data_d     = 1'h0;
                  frame_d    = 1'h0;
               end
            end
         end
         default: begin
            state_d    = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift register, MSB first so alignment bit 9 leads and the N bit ends the word

   generate
      for (g = 0; g < `OH_BITS_PER_FRAME; g = g + 1) begin : sh_bit
         if (g == 0) begin : sh_lsb
            assign sh_d[g] = (take_word | shift_word) ? 1'h0 : sh_q[g];
         end else begin : sh_upper
            assign sh_d[g] = take_word  ? pend_word_q[g-1] :
                             shift_word ? sh_q[g-1]        :
                                          sh_q[g];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pending overhead word
   // A load in the cycle that takes the old word keeps the flag set: the set wins,
   // so the new word is never lost behind the one being started

   always @* begin
      pend_d      = pend_q;
      pend_word_d = pend_word_q;
      overrun_d   = 1'h0;
      if (take_word) begin
         pend_d = 1'h0;
      end
      if (ovh_load) begin
         pend_d      = 1'h1;
         pend_word_d = ovh_word;
         overrun_d   = pend_q & ~take_word;
      end
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         pend_q      <= `OH_PEND_RESET;
         pend_word_q <= WORD_ZERO;
         ovh_overrun <= `OH_OVERRUN_RESET;
      end else begin
         pend_q      <= pend_d;
         pend_word_q <= pend_word_d;
         ovh_overrun <= overrun_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serialiser state registers

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         cnt_q   <= CNT_ZERO;
         sh_q    <= WORD_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pins; the data pin has no enable and is driven at all times

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         rx_overhead_serial_out  <= `OH_DATA_RESET;
         rx_overhead_frame_start <= `OH_FRAME_RESET;
      end else begin
         rx_overhead_serial_out  <= data_d;
         rx_overhead_frame_start <= frame_d;
      end
   end

endmodule

`default_nettype wire

// ==== testbench/e3_rx_overhead_serial_out_test.sv ====
// Testbench for the receive overhead serial port
`timescale 1ns/1ps
`default_nettype none
module e3_rx_overhead_serial_out_test;
   logic mclk = 0, reset = 1, ld = 0, got_v;
   logic [11:0] w = 0, got, ovs = 0;
   wire d, c, f, ov;
   int n_fail = 0, checks = 0, cyc = 0, i;
   always #5 mclk = ~mclk;
   rx_overhead_serial_port dut_u (.mclk(mclk), .reset(reset), .ovh_load(ld), .ovh_word(w), .rx_overhead_serial_out(d),
      .rx_overhead_bit_clock(c), .rx_overhead_frame_start(f), .ovh_overrun(ov));
   e3_term_model term_u (.mclk(mclk), .term_overhead_clock_in(c), .term_frame_start_in(f), .term_data_in(d),
      .got(got), .got_v(got_v));
   always @(posedge mclk) if (ov === 1) ovs <= ovs + 12'h001;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         results;
      end
   end
   task chk(string s, logic [11:0] e, a);
      checks++;
      if (e !== a) begin n_fail++; $display("unexpected %s exp %h got %h", s, e, a); end
   endtask
   task load(logic [11:0] v);
      @(negedge mclk) ld = 1;
      w = v;
      @(negedge mclk) ld = 0;
   endtask
   task rx(logic [11:0] e);
      for (i = 0; i < 300 && got_v !== 1; i++) @(negedge mclk);
      chk("word", e, got);
      @(negedge mclk);
   endtask
   task t_one;
      load(12'h9A5);
      rx(12'h9A5);
      repeat (8) @(negedge mclk);
      chk("idle", 12'h000, {11'h000, d});
      $display("single word done");
   endtask
   task t_ovr;
      load(12'h5C3);
      for (i = 0; i < 50 && f !== 1; i++) @(negedge mclk);
      load(12'h3F0);
      load(12'hC0F);
      rx(12'h5C3);
      rx(12'hC0F);
      chk("overrun", 12'h001, ovs);
      $display("back to back done");
   endtask
   task results;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      reset = 0;
      t_one;
      t_ovr;
      results;
   end
endmodule
bind rx_overhead_serial_port rx_ovh_chk chk_u (.mclk(mclk), .reset(reset), .ovh_load(ovh_load),
   .ovh_overrun(ovh_overrun), .rx_overhead_serial_out(rx_overhead_serial_out),
   .rx_overhead_bit_clock(rx_overhead_bit_clock), .rx_overhead_frame_start(rx_overhead_frame_start));
`default_nettype wire

// ==== testbench/e3_term_model.sv ====
// Terminal equipment model capturing overhead words
`timescale 1ns/1ps
`default_nettype none
module e3_term_model (input wire logic mclk, term_overhead_clock_in, term_frame_start_in, term_data_in,
   output var logic [11:0] got, output var logic got_v);
   logic c_q = 0;
   int n = 0, n_d;
   logic [11:0] sh = 0, sh_d;
   always_comb begin
      n_d = term_frame_start_in ? 1 : (n > 0 && n < 12) ? n + 1 : 0;
      sh_d = {sh[10:0], term_data_in};
   end
   always @(posedge mclk) begin
      c_q <= term_overhead_clock_in;
      got_v <= 0;
      if (term_overhead_clock_in && !c_q) begin
         n <= n_d;
         sh <= sh_d;
         if (n_d == 12) begin
            got <= sh_d;
            got_v <= 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/rx_ovh_checker.sv ====
// Checker for the overhead serial port outputs
`timescale 1ns/1ps
`default_nettype none
module rx_ovh_chk (input wire logic mclk, reset, ovh_load, ovh_overrun,
   input wire logic rx_overhead_serial_out, rx_overhead_bit_clock, rx_overhead_frame_start);
   wire c = rx_overhead_bit_clock;
   wire f = rx_overhead_frame_start;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence hi4; c[*4]; endsequence
   sequence lo4; !c[*4]; endsequence
   data_edge_a: assert property (!$stable(rx_overhead_serial_out) |-> $fell(c)) else $error("data moved");
   clk_high_a: assert property ($rose(c) |-> hi4 ##1 !c) else $error("clock high phase");
   clk_low_a: assert property ($fell(c) |-> lo4 ##1 c) else $error("clock low phase");
   frame_len_a: assert property ($rose(f) |-> f[*8] ##1 !f) else $error("frame start width");
   frame_edge_a: assert property ($rose(f) |-> $fell(c)) else $error("frame start edge");
   frame_gap_a: assert property ($rose(f) |-> ##8 !f[*8]) else $error("frame start repeat");
   overrun_load_a: assert property (ovh_overrun |-> $past(ovh_load)) else $error("overrun without load");
endmodule
`default_nettype wire
